// ===== core/usb_err_pkg.sv
// register map, field positions and timing constants of the usb error flag block
// assumes a 32-bit classic wishbone bus and a 125 MHz peripheral clock
package usb_err_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          FLAG_W          = 8;
    localparam int          DESC_ADDR_W     = 32;
    localparam int          BYTE_CNT_W      = 11;
    localparam logic [7:0]  ERR_FLAGS_OFS   = 8'h00;
    localparam logic [7:0]  ERR_MASK_OFS    = 8'h04;
    localparam logic [7:0]  CTRL_OFS        = 8'h08;
    localparam logic [7:0]  BDT_BASE_OFS    = 8'h0C;
    localparam int          STUFF_BIT       = 7;
    localparam int          DESC_BIT        = 6;
    localparam int          MEM_BIT         = 5;
    localparam int          TURN_BIT        = 4;
    localparam int          PART_BIT        = 3;
    localparam int          DATA_CRC_BIT    = 2;
    localparam int          TOKEN_FRAME_BIT = 1;
    localparam int          PID_BIT         = 0;
    localparam int          CTRL_HOST_BIT   = 0;
    localparam logic [7:0]  FLAGS_RST       = 8'h00;
    localparam logic [7:0]  MASK_RST        = 8'h00;
    localparam logic [31:0] BDT_BASE_RST    = 32'h0000_0000;
    localparam logic [8:0]  BDT_ALIGN_MASK  = 9'h1FF;
    localparam int          TURN_BIT_TIMES  = 16;
    localparam int          TURN_CNT_W      = 5;
    localparam int          GNT_WAIT_NS     = 2000;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          GNT_WAIT_CYC    = GNT_WAIT_NS / CLK_PERIOD_NS;
    localparam int          GNT_CNT_W       = 9;
endpackage

// ===== core/usb_turnaround_timer.sv
// bus turnaround timer: counts idle bit times after an end of packet
// assumes bit_tick_i is a one-cycle strobe per bit time on the same clock
`timescale 1ns/1ps
module usb_turnaround_timer
    import usb_err_pkg::*;
#(
    parameter int LIMIT = TURN_BIT_TIMES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // link events
    input  wire logic eop_i,
    input  wire logic bit_tick_i,
    input  wire logic resp_start_i,
    // result
    output logic      timeout_o
);
    import usb_err_pkg::*;

    logic                  armed_r;
    logic                  armed_nxt;
    logic [TURN_CNT_W-1:0] cnt_r;
    logic [TURN_CNT_W-1:0] cnt_nxt;
    logic                  timeout_r;
    logic                  timeout_nxt;

    always_comb begin
        armed_nxt   = armed_r;
        cnt_nxt     = cnt_r;
        timeout_nxt = 1'b0;
        if (eop_i) begin
            armed_nxt = 1'b1;
            cnt_nxt   = '0;
        end else if (resp_start_i) begin
            armed_nxt = 1'b0;
        end else if (armed_r && bit_tick_i) begin
            // more than LIMIT idle bit times: fire on the tick past LIMIT
            if (cnt_r == TURN_CNT_W'(LIMIT)) begin
                timeout_nxt = 1'b1;
                armed_nxt   = 1'b0;
            end else begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_r   <= 1'b0;
            cnt_r     <= '0;
            timeout_r <= 1'b0;
        end else begin
            armed_r   <= armed_nxt;
            cnt_r     <= cnt_nxt;
            timeout_r <= timeout_nxt;
        end
    end

    assign timeout_o = timeout_r;
endmodule

// ===== core/usb_error_status_flags.sv
// usb link error flags with write-one-clear status, mask and interrupt
// assumes all link inputs come from logic on clk_i; events are one-cycle strobes, mem_req_i and mem_gnt_i are levels
//
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module usb_error_status_flags
    import usb_err_pkg::*;
#(
    parameter int GNT_WAIT = GNT_WAIT_CYC
) (
    // clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             rst_i,
    // wishbone slave
    input  wire logic                             wb_cyc_i,
    input  wire logic                             wb_stb_i,
    input  wire logic                             wb_we_i,
    input  wire logic [usb_err_pkg::ADDR_W-1:0]   wb_adr_i,
    input  wire logic [3:0]                       wb_sel_i,
    input  wire logic [31:0]                      wb_dat_i,
    output logic      [31:0]                      wb_dat_o,
    output logic                                  wb_ack_o,
    // interrupt
    output logic                                  irq_o,
    // receive path events
    input  wire logic                             rx_pkt_end_i,
    input  wire logic                             stuff_err_i,
    input  wire logic                             data_crc_fail_i,
    input  wire logic                             token_crc_fail_i,
    input  wire logic [2:0]                       rx_bit_rem_i,
    input  wire logic                             rx_data_end_i,
    input  wire logic                             pid_valid_i,
    input  wire logic [7:0]                       pid_i,
    output logic                                  rx_reject_o,
    // buffer descriptors and memory bus
    input  wire logic                             desc_fetch_i,
    input  wire logic [usb_err_pkg::DESC_ADDR_W-1:0] buf_addr_i,
    input  wire logic                             mem_req_i,
    input  wire logic                             mem_gnt_i,
    input  wire logic                             rx_start_i,
    input  wire logic [usb_err_pkg::BYTE_CNT_W-1:0] buf_len_i,
    input  wire logic                             rx_byte_i,
    // turnaround and framing
    input  wire logic                             eop_i,
    input  wire logic                             bit_tick_i,
    input  wire logic                             resp_start_i,
    input  wire logic                             sof_zero_i,
    input  wire logic                             link_busy_i
);
    import usb_err_pkg::*;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // bus state
    logic        ack_r;
    logic        ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;
    // registers
    logic [FLAG_W-1:0] flags_r;
    logic [FLAG_W-1:0] flags_nxt;
    logic [FLAG_W-1:0] mask_r;
    logic [FLAG_W-1:0] mask_nxt;
    logic              host_r;
    logic              host_nxt;
    logic [31:0]       bdt_base_r;
    logic [31:0]       bdt_base_nxt;
    logic              irq_r;
    logic              irq_nxt;
    // link side state
    logic                  reject_r;
    logic                  reject_nxt;
    logic [GNT_CNT_W-1:0]  gnt_cnt_r;
    logic [GNT_CNT_W-1:0]  gnt_cnt_nxt;
    logic [BYTE_CNT_W-1:0] byte_cnt_r;
    logic [BYTE_CNT_W-1:0] byte_cnt_nxt;
    logic [BYTE_CNT_W-1:0] len_r;
    logic [BYTE_CNT_W-1:0] len_nxt;
    logic                  trunc_r;
    logic                  trunc_nxt;
    // decoded events
    logic              bus_req;
    logic              wr_req;
    logic              turn_timeout;
    logic              gnt_late;
    logic              trunc_ev;
    logic              desc_bad;
    logic              pid_bad;
    logic [FLAG_W-1:0] set_v;
    logic [FLAG_W-1:0] clr_v;

    usb_turnaround_timer #(
        .LIMIT        (TURN_BIT_TIMES)
    ) u_turn (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .eop_i        (eop_i),
        .bit_tick_i   (bit_tick_i),
        .resp_start_i (resp_start_i),
        .timeout_o    (turn_timeout)
    );

    assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
    // writes land on the edge where the master samples ack high
    assign wr_req  = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

    // descriptor table base must be aligned, buffer must not be null
    always_comb begin
        desc_bad = 1'b0;
        if (desc_fetch_i) begin
            desc_bad = (bdt_base_r[8:0] & BDT_ALIGN_MASK) != 9'h000
                    || bdt_base_r == 32'h0000_0000
                    || buf_addr_i == '0;
        end
    end

    // check field is the ones complement of the type field
    assign pid_bad = pid_valid_i && (pid_i[7:4] != ~pid_i[3:0]);

    // memory grant wait and receive buffer fill
    always_comb begin
        gnt_cnt_nxt  = '0;
        gnt_late     = 1'b0;
        byte_cnt_nxt = byte_cnt_r;
        len_nxt      = len_r;
        trunc_nxt    = trunc_r;
        trunc_ev     = 1'b0;
        if (mem_req_i && !mem_gnt_i) begin
            if (gnt_cnt_r == GNT_CNT_W'(GNT_WAIT - 1)) begin
                // step past the limit so one long wait reports once
                gnt_late    = 1'b1;
                gnt_cnt_nxt = gnt_cnt_r + 1'b1;
            end else if (gnt_cnt_r < GNT_CNT_W'(GNT_WAIT - 1)) begin
                gnt_cnt_nxt = gnt_cnt_r + 1'b1;
            end else begin
                gnt_cnt_nxt = gnt_cnt_r;
            end
        end
        if (rx_start_i) begin
            byte_cnt_nxt = '0;
            len_nxt      = buf_len_i;
            trunc_nxt    = 1'b0;
        end else if (rx_byte_i) begin
            if (byte_cnt_r == len_r) begin
                // only the first byte that overflows is reported
                trunc_ev  = !trunc_r;
                trunc_nxt = 1'b1;
            end else begin
                byte_cnt_nxt = byte_cnt_r + 1'b1;
            end
        end
    end

    always_comb begin
        set_v                  = '0;
        set_v[STUFF_BIT]       = stuff_err_i;
        set_v[DESC_BIT]        = desc_bad;
        set_v[MEM_BIT]         = gnt_late || trunc_ev;
        set_v[TURN_BIT]        = turn_timeout;
        set_v[PART_BIT]        = rx_data_end_i && rx_bit_rem_i != 3'h0;
        set_v[DATA_CRC_BIT]    = data_crc_fail_i;
        // device mode: token check; host mode: frame counter ran out mid-transfer
        set_v[TOKEN_FRAME_BIT] = host_r ? (sof_zero_i && link_busy_i)
                                        : token_crc_fail_i;
        set_v[PID_BIT]         = pid_bad;
    end

    // packet rejected on stuffing or data check failure at packet end
    assign reject_nxt = rx_pkt_end_i && (stuff_err_i || data_crc_fail_i);

    // register writes; a set arriving with its clear wins
    always_comb begin
        clr_v        = '0;
        mask_nxt     = mask_r;
        host_nxt     = host_r;
        bdt_base_nxt = bdt_base_r;
        if (wr_req && wb_sel_i[0]) begin
            case (wb_adr_i)
                ERR_FLAGS_OFS: clr_v = wb_dat_i[FLAG_W-1:0];
                ERR_MASK_OFS:  mask_nxt = wb_dat_i[FLAG_W-1:0];
                CTRL_OFS:      host_nxt = wb_dat_i[CTRL_HOST_BIT];
                default: begin
                end
            endcase
        end
        if (wr_req && wb_adr_i == BDT_BASE_OFS) begin
            bdt_base_nxt = merge_bytes(bdt_base_r, wb_dat_i, wb_sel_i);
        end
        flags_nxt = (flags_r & ~clr_v) | set_v;
        irq_nxt   = |(flags_nxt & mask_nxt);
    end

    // read mux and single-cycle acknowledge; unmapped reads return zero
    always_comb begin
        ack_nxt = bus_req;
        dat_nxt = dat_r;
        if (bus_req) begin
            case (wb_adr_i)
                ERR_FLAGS_OFS: dat_nxt = {24'h00_0000, flags_r};
                ERR_MASK_OFS:  dat_nxt = {24'h00_0000, mask_r};
                CTRL_OFS:      dat_nxt = {31'h0000_0000, host_r};
                BDT_BASE_OFS:  dat_nxt = bdt_base_r;
                default:       dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r      <= 1'b0;
            dat_r      <= 32'h0000_0000;
            flags_r    <= FLAGS_RST;
            mask_r     <= MASK_RST;
            host_r     <= 1'b0;
            bdt_base_r <= BDT_BASE_RST;
            irq_r      <= 1'b0;
            reject_r   <= 1'b0;
            gnt_cnt_r  <= '0;
            byte_cnt_r <= '0;
            len_r      <= '0;
            trunc_r    <= 1'b0;
        end else begin
            ack_r      <= ack_nxt;
            dat_r      <= dat_nxt;
            flags_r    <= flags_nxt;
            mask_r     <= mask_nxt;
            host_r     <= host_nxt;
            bdt_base_r <= bdt_base_nxt;
            irq_r      <= irq_nxt;
            reject_r   <= reject_nxt;
            gnt_cnt_r  <= gnt_cnt_nxt;
            byte_cnt_r <= byte_cnt_nxt;
            len_r      <= len_nxt;
            trunc_r    <= trunc_nxt;
        end
    end

    assign wb_ack_o    = ack_r;
    assign wb_dat_o    = dat_r;
    assign irq_o       = irq_r;
    assign rx_reject_o = reject_r;
endmodule

// ===== sim/usb_error_status_flags_checker.sv
// checker: port-level properties of the usb error flag block
// assumes one clock domain and the block's synchronous active-high reset
`timescale 1ns/1ps
module usb_error_status_flags_checker
    import usb_err_pkg::*;
(
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_we_i,
    input wire logic [ADDR_W-1:0]         wb_adr_i,
    input wire logic [31:0]               wb_dat_o,
    input wire logic                      wb_ack_o,
    input wire logic                      irq_o,
    input wire logic                      rx_pkt_end_i,
    input wire logic                      stuff_err_i,
    input wire logic                      data_crc_fail_i,
    input wire logic                      token_crc_fail_i,
    input wire logic                      rx_data_end_i,
    input wire logic                      pid_valid_i,
    input wire logic                      desc_fetch_i,
    input wire logic                      mem_req_i,
    input wire logic                      rx_byte_i,
    input wire logic                      bit_tick_i,
    input wire logic                      sof_zero_i,
    input wire logic                      rx_reject_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_upper_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i == ERR_FLAGS_OFS
        |-> wb_dat_o[31:8] == 24'h0) else $error("flag upper bits not zero");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > BDT_BASE_OFS
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    a_read_held: assert property (!wb_ack_o |-> $stable(wb_dat_o))
        else $error("read data moved outside an access");
    a_reject_on_err: assert property (rx_pkt_end_i && (stuff_err_i || data_crc_fail_i)
        |=> rx_reject_o) else $error("bad packet not rejected");
    a_reject_cause: assert property (rx_reject_o |->
        $past(rx_pkt_end_i && (stuff_err_i || data_crc_fail_i)))
        else $error("reject without cause");
    a_irq_rise: assert property ($rose(irq_o) |-> $past(wb_ack_o && wb_we_i)
        || $past(bit_tick_i, 2) || $past(stuff_err_i || data_crc_fail_i
        || token_crc_fail_i || rx_data_end_i || pid_valid_i || desc_fetch_i
        || mem_req_i || rx_byte_i || sof_zero_i)) else $error("irq without event");
    a_irq_fall: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
        else $error("irq dropped without a write");
endmodule
bind usb_error_status_flags usb_error_status_flags_checker chk (.*);

// ===== sim/usb_link_partner.sv
// far side model: end of packet, bit-time ticks, optional reply
// assumes send_i is a one-cycle pulse; ticks stand still outside a frame
`timescale 1ns/1ps
module usb_link_partner (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // bench commands
    input  wire logic send_i,
    input  wire logic slow_i,
    // link events
    output logic      eop_o,
    output logic      bit_tick_o,
    output logic      resp_start_o
);
    logic [5:0] tick_n_r;
    logic       run_r;
    logic       ph_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            run_r <= 1'b0;
            ph_r <= 1'b0;
            tick_n_r <= 6'h00;
            eop_o <= 1'b0;
            bit_tick_o <= 1'b0;
            resp_start_o <= 1'b0;
        end else begin
            eop_o <= send_i;
            ph_r <= run_r & ~ph_r;
            bit_tick_o <= run_r & ph_r;
            // prompt reply after 8 bit times, slow never replies
            resp_start_o <= run_r & ph_r & ~slow_i & (tick_n_r == 6'h08);
            tick_n_r <= send_i ? 6'h00 : tick_n_r + {5'h0, bit_tick_o};
            if (send_i) run_r <= 1'b1;
            else if (resp_start_o || tick_n_r == 6'h14) run_r <= 1'b0;
        end
    end
endmodule

// ===== sim/test_usb_error_status_flags.sv
// bench: register access, every error event, mask, irq and reject
// assumes the partner model drives end of packet, ticks and replies
`timescale 1ns/1ps
module test_usb_error_status_flags;
    import usb_err_pkg::*;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = 0, pid_i = 0, e;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 0, wb_dat_o, buf_addr_i = 0, r, exp_q[$];
    logic wb_ack_o, irq_o, rx_reject_o, eop_i, bit_tick_i, resp_start_i;
    logic rx_pkt_end_i = 0, stuff_err_i = 0, data_crc_fail_i = 0, token_crc_fail_i = 0;
    logic rx_data_end_i = 0, pid_valid_i = 0, desc_fetch_i = 0, mem_req_i = 0;
    logic mem_gnt_i = 1, rx_start_i = 0, rx_byte_i = 0, sof_zero_i = 0, link_busy_i = 0;
    logic send = 0, slow = 0;
    logic [2:0] rx_bit_rem_i = 0;
    logic [10:0] buf_len_i = 0;
    int n_errors = 0, tests_run = 0;
    integer seed = 32'he2f3;
    always #4 clk_i = ~clk_i;
    usb_error_status_flags #(.GNT_WAIT(4)) dut (.*);
    usb_link_partner far (.clk_i(clk_i), .rst_i(rst_i), .send_i(send), .slow_i(slow),
        .eop_o(eop_i), .bit_tick_o(bit_tick_i), .resp_start_o(resp_start_i));
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want) begin
            n_errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask
    always @(posedge clk_i)
        if (!rst_i && wb_ack_o && !wb_we_i)
            check(wb_dat_o, exp_q.size() ? exp_q.pop_front() : 32'hBAD);
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] x);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        if (!w) exp_q.push_back(x);
        n = 0;
        do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        if (n >= 20) begin n_errors++; print_verdict; end
    endtask
    task automatic fire(input int k);
        r = $random(seed);
        case (k)
            0: begin pid_i <= {r[3:0], r[3:0]}; pid_valid_i <= 1'b1; end
            1: token_crc_fail_i <= 1'b1;
            2: begin data_crc_fail_i <= 1'b1; rx_pkt_end_i <= 1'b1; end
            3: begin rx_bit_rem_i <= r[2:0] | 3'h1; rx_data_end_i <= 1'b1; end
            4: begin slow <= 1'b1; send <= 1'b1; end
            5: begin rx_start_i <= 1'b1; buf_len_i <= 11'h001; end
            6: begin desc_fetch_i <= 1'b1; buf_addr_i <= 32'h0; end
            7: begin stuff_err_i <= 1'b1; rx_pkt_end_i <= 1'b1; end
            8: begin mem_req_i <= 1'b1; mem_gnt_i <= 1'b0; end
            9: begin slow <= 1'b0; send <= 1'b1; end
            10: begin link_busy_i <= 1'b1; sof_zero_i <= 1'b1; end
            11: rx_pkt_end_i <= 1'b1;
            default: begin desc_fetch_i <= 1'b1; buf_addr_i <= {r[31:1], 1'b1}; end
        endcase
        @(posedge clk_i);
        {pid_valid_i, token_crc_fail_i, data_crc_fail_i, rx_pkt_end_i, rx_data_end_i,
         rx_start_i, desc_fetch_i, stuff_err_i, send, sof_zero_i} <= '0;
        @(posedge clk_i);
        check({31'h0, rx_reject_o}, {31'h0, k == 2 || k == 7});
        if (k == 5) begin
            rx_byte_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            rx_byte_i <= 1'b0;
        end
        repeat (k == 4 || k == 9 ? 60 : 8) @(posedge clk_i);
        mem_req_i <= 1'b0;
        mem_gnt_i <= 1'b1;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(0, ERR_FLAGS_OFS, 0, 0);
        wb(0, 8'h10, 0, 0);
        wb(1, ERR_MASK_OFS, 32'hFFFF_FF7F, 0);
        wb(0, ERR_MASK_OFS, 0, 32'h7F);
        wb(1, BDT_BASE_OFS, 32'h400, 0);
        for (int k = 0; k < 13; k++) begin
            e = k < 8 ? 8'h01 << k : k == 8 ? 8'h20 : k == 10 ? 8'h02 : 8'h00;
            if (k == 10) wb(1, CTRL_OFS, 32'h1, 0);
            fire(k);
            wb(0, ERR_FLAGS_OFS, 0, {24'h0, e});
            check({31'h0, irq_o}, {31'h0, |(e & 8'h7F)});
            wb(1, ERR_FLAGS_OFS, {r[31:8], ~e}, 0);
            wb(0, ERR_FLAGS_OFS, 0, {24'h0, e});
            wb(1, ERR_FLAGS_OFS, {24'h0, e}, 0);
            wb(0, ERR_FLAGS_OFS, 0, 0);
            check({31'h0, irq_o}, 32'h0);
        end
        print_verdict;
    end
endmodule
